// ==== src/snpce_pkg.sv ====
// Purpose: Constants and types for the serial NVM program command engine
// Assumes: 40 MHz system clock; serial clock and data arrive asynchronously
// Notes: Shared by the engine, its checker and the bench
package snpce_pkg;
  localparam int PTR_W = 22;
  localparam int CMD_BITS = 8;
  localparam int PAYLOAD_BITS = 24;
  localparam int DATA_W = 16;
  localparam logic [4:0] LAST_CMD_BIT = 5'h07;
  localparam logic [4:0] LAST_PAY_BIT = 5'h17;
  localparam logic [4:0] DATA_LSB_POS = 5'h01;
  localparam logic [4:0] DATA_MSB_POS = 5'h10;
  localparam logic [7:0] CMD_LOAD = 8'h00;
  localparam logic [7:0] CMD_LOAD_INC = 8'h02;
  localparam logic [7:0] CMD_READ = 8'hfc;
  localparam logic [7:0] CMD_READ_INC = 8'hfe;
  localparam logic [7:0] CMD_PTR_LOAD = 8'h80;
  localparam logic [7:0] CMD_INC = 8'hf8;
  localparam logic [7:0] CMD_BULK = 8'h18;
  localparam logic [7:0] CMD_ROW = 8'hf0;
  localparam logic [7:0] CMD_PROG_INT = 8'he0;
  localparam logic [7:0] CMD_PROG_EXT = 8'hc0;
  localparam logic [7:0] CMD_PROG_END = 8'h82;
  localparam int ADV_BIT = 1;
  // Address ranges of the memory spaces
  localparam logic [PTR_W-1:0] FLASH_LAST = 22'h01ffff;
  localparam logic [PTR_W-1:0] UID_FIRST = 22'h200000;
  localparam logic [PTR_W-1:0] UID_LAST = 22'h20001f;
  localparam logic [PTR_W-1:0] CFG_FIRST = 22'h300000;
  localparam logic [PTR_W-1:0] CFG_LAST = 22'h30001f;
  localparam logic [PTR_W-1:0] EE_FIRST = 22'h310000;
  localparam logic [PTR_W-1:0] EE_LAST = 22'h3effff;
  localparam logic [PTR_W-1:0] FLASH_STEP = 22'h000002;
  localparam logic [PTR_W-1:0] EE_STEP = 22'h000001;
  // Self-timed durations in microseconds
  localparam int CLK_MHZ = 40;
  localparam int SELF_TIMED_WRITE_DELAY_US = 3;
  localparam int ROW_ERASE_TIME_US = 3;
  localparam int BULK_ERASE_TIME_US = 11;
  localparam int SELF_TIMED_CYCLES = SELF_TIMED_WRITE_DELAY_US * CLK_MHZ;
  localparam int ROW_ERASE_CYCLES = ROW_ERASE_TIME_US * CLK_MHZ;
  localparam int BULK_ERASE_CYCLES = BULK_ERASE_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    SNPCE_CMD = 3'b000,
    SNPCE_PAY = 3'b001,
    SNPCE_BUSY = 3'b010,
    SNPCE_EXT = 3'b011
  } snpce_state_t;

  typedef enum logic [2:0] {
    SNPCE_OP_NONE = 3'b000,
    SNPCE_OP_WRITE = 3'b001,
    SNPCE_OP_ROW = 3'b010,
    SNPCE_OP_BULK = 3'b011
  } snpce_op_t;
endpackage

// ==== src/snpce_fifo.sv ====
// Purpose: Flip-flop FIFO for readback words headed to the serial shifter
// Assumes: Single clock, synchronous to the engine
// Notes: Full and empty are exact; push when full is refused
`timescale 1ns/10ps
module snpce_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } snpce_fifo_t;
  snpce_fifo_t st_reg;
  snpce_fifo_t st_next;
  logic push;
  logic pop;

  assign o_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign o_valid = (st_reg.cnt != '0);
  assign o_data = st_reg.mem[st_reg.rd];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = i_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + AW'(1);
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + AW'(1);
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // snpce_fifo

// ==== src/snpce_engine.sv ====
// Purpose: Device-side serial NVM program command engine
// Assumes: Host makes all serial clocks; memory array sits outside behind a
//   simple strobe port; fuse-latched lock bit arrives as a level
// Notes: Serial clock is oversampled; one bit per falling edge
`timescale 1ns/10ps
module snpce_engine
  import snpce_pkg::*;
#(
  parameter int ROW_WORDS = 32,
  parameter int FIFO_DEPTH = 32,
  parameter int SELF_CYC = SELF_TIMED_CYCLES,
  parameter int ROW_CYC = ROW_ERASE_CYCLES,
  parameter int BULK_CYC = BULK_ERASE_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Serial link
  input wire logic I_SERIAL_CLOCK_LINE,
  input wire logic I_SERIAL_DATA_LINE,
  output logic O_SERIAL_DATA_LINE,
  output logic O_SERIAL_DATA_LINE_OE,
  // Protection
  input wire logic I_CODE_LOCK_BIT_N,
  // Memory array port
  output logic O_MEM_READ,
  output logic [PTR_W-1:0] O_MEM_ADDR,
  input wire logic [DATA_W-1:0] I_MEM_RDATA,
  output logic O_MEM_WRITE,
  output logic [PTR_W-1:0] O_MEM_WADDR,
  output logic [DATA_W-1:0] O_MEM_WDATA,
  output logic O_MEM_ROW_ERASE,
  output logic O_ERASE_FLASH,
  output logic O_ERASE_EE,
  output logic O_ERASE_UID,
  output logic O_ERASE_CFG,
  // Status
  output logic O_BUSY,
  output logic [PTR_W-1:0] O_LOCATION_POINTER
);
  localparam int LW = $clog2(ROW_WORDS);
  localparam int TW = 16;

  typedef struct packed {
    logic [2:0] sck_sync;
    logic [1:0] sda_sync;
    logic [1:0] lock_sync;
    snpce_state_t state;
    logic [4:0] bit_cnt;
    logic [7:0] cmd;
    logic [PAYLOAD_BITS-1:0] shreg;
    logic [PTR_W-1:0] ptr;
    logic [ROW_WORDS-1:0][DATA_W-1:0] latch;
    logic [TW-1:0] timer;
    snpce_op_t op;
    logic [PTR_W-1:0] op_addr;
    logic [LW:0] wr_idx;
    logic locked;
    logic rd_req;
    logic [PAYLOAD_BITS-1:0] out_sh;
    logic oe;
    logic dout;
    logic mem_wr;
    logic [PTR_W-1:0] mem_waddr;
    logic [DATA_W-1:0] mem_wdata;
    logic row_erase;
    logic [3:0] bulk;
  } snpce_st_t;

  snpce_st_t st_reg;
  snpce_st_t st_next;
  logic fall;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic fifo_pop;

  function automatic logic in_ee(input logic [PTR_W-1:0] a);
    in_ee = (a >= EE_FIRST) && (a <= EE_LAST);
  endfunction

  function automatic logic in_flash(input logic [PTR_W-1:0] a);
    in_flash = (a <= FLASH_LAST);
  endfunction

  function automatic logic in_cfg(input logic [PTR_W-1:0] a);
    in_cfg = (a >= CFG_FIRST) && (a <= CFG_LAST);
  endfunction

  function automatic logic [LW-1:0] lat_idx(input logic [PTR_W-1:0] a);
    // Flash words are two bytes apart; EEPROM bytes one apart
    lat_idx = in_ee(a) ? a[LW-1:0] : a[LW:1];
  endfunction

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] a);
    bump = in_ee(a) ? a + EE_STEP : a + FLASH_STEP;
  endfunction

  // Readback words queue here so the shifter never waits on the array
  snpce_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_snpce_fifo (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_valid(st_reg.rd_req),
    .o_ready(fifo_in_ready),
    .i_data(I_MEM_RDATA),
    .o_valid(fifo_out_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_out_data)
  );

  // Falling edge seen on the second and third sync stages only
  assign fall = st_reg.sck_sync[2] && !st_reg.sck_sync[1];
  // Every readback takes its own word, so no stale word lingers
  assign fifo_pop = fifo_out_valid && (st_reg.state == SNPCE_PAY) && fall
                    && (st_reg.bit_cnt == 5'h00) && (st_reg.cmd[7:2] == CMD_READ[7:2]);

  always_comb begin
    logic [PAYLOAD_BITS-1:0] frame;
    logic [LW-1:0] widx;
    logic [CMD_BITS-1:0] code;
    frame = '0;
    widx = '0;
    code = {st_reg.cmd[6:0], st_reg.sda_sync[1]};
    st_next = st_reg;
    st_next.sck_sync = {st_reg.sck_sync[1:0], I_SERIAL_CLOCK_LINE};
    st_next.sda_sync = {st_reg.sda_sync[0], I_SERIAL_DATA_LINE};
    st_next.rd_req = 1'b0;
    st_next.mem_wr = 1'b0;
    st_next.row_erase = 1'b0;
    st_next.bulk = 4'h0;
    case (st_reg.state)
      SNPCE_CMD: begin
        if (fall) begin
          st_next.cmd = code;
          st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
          if (st_reg.bit_cnt == LAST_CMD_BIT) begin
            st_next.bit_cnt = 5'h00;
            case (code)
              CMD_LOAD, CMD_LOAD_INC, CMD_PTR_LOAD: begin
                st_next.state = SNPCE_PAY;
                st_next.oe = 1'b0;
              end
              CMD_READ, CMD_READ_INC: begin
                st_next.state = SNPCE_PAY;
                st_next.rd_req = fifo_in_ready;
                st_next.oe = 1'b0;
              end
              CMD_INC: st_next.ptr = bump(st_reg.ptr);
              CMD_BULK: begin
                st_next.bulk[0] = in_flash(st_reg.ptr) || in_cfg(st_reg.ptr);
                st_next.bulk[1] = (in_flash(st_reg.ptr) || in_cfg(st_reg.ptr)
                                   ? st_reg.locked : 1'b0) || in_ee(st_reg.ptr);
                st_next.bulk[2] = in_cfg(st_reg.ptr);
                st_next.bulk[3] = in_flash(st_reg.ptr) || in_cfg(st_reg.ptr);
                st_next.locked = 1'b0;
                st_next.timer = TW'(BULK_CYC);
                st_next.state = SNPCE_BUSY;
              end
              CMD_ROW: begin
                if (!st_reg.locked) begin
                  st_next.row_erase = 1'b1;
                  st_next.op_addr = st_reg.ptr;
                  st_next.timer = TW'(ROW_CYC);
                  st_next.state = SNPCE_BUSY;
                end
              end
              CMD_PROG_INT, CMD_PROG_EXT: begin
                // Protected panels never see a write, self-timed or not
                if (!st_reg.locked) begin
                  st_next.op = SNPCE_OP_WRITE;
                  st_next.op_addr = st_reg.ptr;
                  st_next.wr_idx = '0;
                  st_next.timer = TW'(SELF_CYC);
                  st_next.state = (code[5]) ? SNPCE_BUSY : SNPCE_EXT;
                end
              end
              default: ;
            endcase
          end
        end
      end
      SNPCE_PAY: begin
        if (fall) begin
          st_next.shreg = {st_reg.shreg[PAYLOAD_BITS-2:0], st_reg.sda_sync[1]};
          st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
          if ((st_reg.cmd == CMD_READ || st_reg.cmd == CMD_READ_INC)) begin
            if (st_reg.bit_cnt == 5'h00) begin
              // Code flash hides its contents while locked; IDs do not
              frame[DATA_MSB_POS -: DATA_W] =
                (st_reg.locked && in_flash(st_reg.ptr)) ? '0 : fifo_out_data;
              st_next.out_sh = frame;
              st_next.oe = 1'b1;
              st_next.dout = frame[PAYLOAD_BITS-1];
            end else begin
              st_next.dout = st_reg.out_sh[PAYLOAD_BITS-1 - st_reg.bit_cnt];
            end
          end
          if (st_reg.bit_cnt == LAST_PAY_BIT) begin
            st_next.bit_cnt = 5'h00;
            st_next.oe = 1'b0;
            st_next.state = SNPCE_CMD;
            frame = {st_reg.shreg[PAYLOAD_BITS-2:0], st_reg.sda_sync[1]};
            if (st_reg.cmd == CMD_PTR_LOAD) begin
              st_next.ptr = frame[DATA_LSB_POS +: PTR_W];
            end else if (st_reg.cmd == CMD_LOAD || st_reg.cmd == CMD_LOAD_INC) begin
              widx = lat_idx(st_reg.ptr);
              st_next.latch[widx] = in_ee(st_reg.ptr)
                ? {8'hff, frame[DATA_LSB_POS +: 8]}
                : frame[DATA_LSB_POS +: DATA_W];
            end
            if (st_reg.cmd[ADV_BIT]) begin
              st_next.ptr = bump(st_reg.ptr);
            end
          end
        end
      end
      SNPCE_BUSY, SNPCE_EXT: begin
        if (st_reg.op == SNPCE_OP_WRITE) begin
          // Row for flash, one word or byte elsewhere, none for config in SNPCE_EXT
          if (!in_flash(st_reg.op_addr) && st_reg.wr_idx == '0) begin
            st_next.mem_wr = !(st_reg.state == SNPCE_EXT && in_cfg(st_reg.op_addr));
            st_next.mem_waddr = st_reg.op_addr;
            st_next.mem_wdata = st_reg.latch[lat_idx(st_reg.op_addr)];
            st_next.wr_idx = (LW+1)'(ROW_WORDS);
          end else if (st_reg.wr_idx != (LW+1)'(ROW_WORDS)) begin
            widx = st_reg.wr_idx[LW-1:0];
            st_next.mem_wr = 1'b1;
            st_next.mem_waddr = {st_reg.op_addr[PTR_W-1:LW+1], widx, 1'b0};
            st_next.mem_wdata = st_reg.latch[widx];
            st_next.wr_idx = st_reg.wr_idx + (LW+1)'(1);
          end
        end
        if (st_reg.state == SNPCE_EXT) begin
          if (fall) begin
            st_next.cmd = {st_reg.cmd[6:0], st_reg.sda_sync[1]};
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == LAST_CMD_BIT) begin
              st_next.bit_cnt = 5'h00;
              st_next.state = SNPCE_CMD;
              st_next.op = SNPCE_OP_NONE;
              st_next.latch = '1;
            end
          end
        end else if (st_reg.timer != '0) begin
          st_next.timer = st_reg.timer - TW'(1);
        end else begin
          st_next.state = SNPCE_CMD;
          if (st_reg.op == SNPCE_OP_WRITE) begin
            st_next.latch = '1;
          end
          st_next.op = SNPCE_OP_NONE;
        end
      end
      default: st_next.state = SNPCE_CMD;
    endcase
    st_next.lock_sync = {st_reg.lock_sync[0], !I_CODE_LOCK_BIT_N};
    // Fuse lock is merged in only while idle and then held until a bulk erase clears it, so no command sees it change
    if (st_reg.state == SNPCE_CMD && st_reg.bit_cnt == 5'h00 && st_reg.op == SNPCE_OP_NONE
        && !st_next.bulk[0] && !st_next.bulk[1]) begin
      st_next.locked = st_next.locked | st_reg.lock_sync[1];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_reg <= '0;
      st_reg.latch <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_SERIAL_DATA_LINE = st_reg.dout;
  assign O_SERIAL_DATA_LINE_OE = st_reg.oe;
  assign O_MEM_READ = st_reg.rd_req;
  assign O_MEM_ADDR = st_reg.ptr;
  assign O_MEM_WRITE = st_reg.mem_wr;
  assign O_MEM_WADDR = st_reg.mem_waddr;
  assign O_MEM_WDATA = st_reg.mem_wdata;
  assign O_MEM_ROW_ERASE = st_reg.row_erase;
  assign O_ERASE_FLASH = st_reg.bulk[0];
  assign O_ERASE_EE = st_reg.bulk[1];
  assign O_ERASE_UID = st_reg.bulk[2];
  assign O_ERASE_CFG = st_reg.bulk[3];
  assign O_BUSY = (st_reg.state == SNPCE_BUSY) || (st_reg.state == SNPCE_EXT);
  assign O_LOCATION_POINTER = st_reg.ptr;
endmodule // snpce_engine

// ==== sim/snpce_engine_monitor.sv ====
// Purpose: Port checks on the program command engine
// Assumes: Lock fuse held steady around each command
// Notes: Edge count leads the device by two sampling flops
`timescale 1ns/10ps
module snpce_engine_monitor
  import snpce_pkg::*;
#(
  parameter int BULK_CYC = BULK_ERASE_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_SERIAL_CLOCK_LINE,
  input wire logic I_CODE_LOCK_BIT_N,
  input wire logic O_SERIAL_DATA_LINE_OE,
  input wire logic O_MEM_WRITE,
  input wire logic [PTR_W-1:0] O_MEM_WADDR,
  input wire logic O_MEM_ROW_ERASE,
  input wire logic O_ERASE_FLASH,
  input wire logic O_ERASE_EE,
  input wire logic O_ERASE_UID,
  input wire logic O_ERASE_CFG,
  input wire logic O_BUSY
);
  typedef struct packed {
    logic sclk;
    logic [4:0] oe_cnt;
    logic [9:0] busy_cnt;
  } snpce_mon_t;
  snpce_mon_t mon_reg;
  snpce_mon_t mon_next;
  always_comb begin
    mon_next = mon_reg;
    mon_next.sclk = I_SERIAL_CLOCK_LINE;
    if (!O_SERIAL_DATA_LINE_OE) mon_next.oe_cnt = 5'h00;
    else if (mon_reg.sclk && !I_SERIAL_CLOCK_LINE) mon_next.oe_cnt = mon_reg.oe_cnt + 5'h01;
    mon_next.busy_cnt = O_BUSY ? mon_reg.busy_cnt + 10'h001 : 10'h000;
  end
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) mon_reg <= '0;
    else mon_reg <= mon_next;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_locked_no_write: assert property (!(O_MEM_WRITE && !I_CODE_LOCK_BIT_N &&
    (O_MEM_WADDR <= FLASH_LAST || O_MEM_WADDR >= EE_FIRST))) else $error("write while locked");
  a_row_locked: assert property (O_MEM_ROW_ERASE |-> I_CODE_LOCK_BIT_N)
    else $error("row erase while locked");
  a_row_single: assert property (O_MEM_ROW_ERASE |=> !O_MEM_ROW_ERASE)
    else $error("row erase repeated");
  a_bulk_cfg_flash: assert property (O_ERASE_FLASH |-> O_ERASE_CFG)
    else $error("flash erase without config");
  a_bulk_uid_set: assert property (O_ERASE_UID |-> O_ERASE_FLASH && O_ERASE_CFG)
    else $error("id erase without flash");
  a_bulk_ee_locked: assert property (O_ERASE_FLASH && !I_CODE_LOCK_BIT_N |-> O_ERASE_EE)
    else $error("locked bulk spared eeprom");
  a_readback_edges: assert property (O_SERIAL_DATA_LINE_OE |-> mon_reg.oe_cnt <= 5'h17)
    else $error("data line held too long");
  a_oe_not_busy: assert property (O_BUSY |-> !O_SERIAL_DATA_LINE_OE)
    else $error("data line driven while busy");
  a_busy_bounded: assert property (mon_reg.busy_cnt <= BULK_CYC + 300)
    else $error("busy too long");
  c_write: cover property (O_MEM_WRITE);
  c_readback: cover property ($fell(O_SERIAL_DATA_LINE_OE));
  c_bulk_ids: cover property (O_ERASE_FLASH && O_ERASE_UID);
endmodule // snpce_engine_monitor

bind snpce_engine snpce_engine_monitor #(.BULK_CYC(BULK_CYC)) u_snpce_engine_monitor (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_SERIAL_CLOCK_LINE(I_SERIAL_CLOCK_LINE),
  .I_CODE_LOCK_BIT_N(I_CODE_LOCK_BIT_N), .O_SERIAL_DATA_LINE_OE(O_SERIAL_DATA_LINE_OE),
  .O_MEM_WRITE(O_MEM_WRITE), .O_MEM_WADDR(O_MEM_WADDR), .O_MEM_ROW_ERASE(O_MEM_ROW_ERASE),
  .O_ERASE_FLASH(O_ERASE_FLASH), .O_ERASE_EE(O_ERASE_EE), .O_ERASE_UID(O_ERASE_UID),
  .O_ERASE_CFG(O_ERASE_CFG), .O_BUSY(O_BUSY));

// ==== sim/snpce_host.sv ====
// Purpose: Programming host model making the link clock
// Assumes: 200 ns bit period, clock idles low between frames
// Notes: Releases the data line for the whole readback payload
`timescale 1ns/10ps
module snpce_host (
  output logic o_sclk,
  output logic o_sdat,
  output logic o_sdat_oe,
  input wire logic i_sdat
);
  initial begin
    o_sclk = 1'b0;
    o_sdat = 1'b0;
    o_sdat_oe = 1'b1;
  end
  task automatic put(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_sdat = v[i];
      #100 o_sclk = 1'b0;
      #100;
    end
  endtask
  // Device drives the line only from the first fall on, so the first fall is not sampled
  task automatic get(output logic [15:0] d);
    logic [23:0] w;
    o_sdat_oe = 1'b0;
    for (int i = 1; i <= 24; i++) begin
      o_sclk = 1'b1;
      #100 o_sclk = 1'b0;
      if (i > 1) w = {w[22:0], i_sdat};
      #100;
    end
    o_sdat_oe = 1'b1;
    d = w[15:0];
  endtask
endmodule // snpce_host

// ==== sim/snpce_engine_test.sv ====
// Purpose: Self-checking bench for the program command engine
// Assumes: Memory read data is a fixed pattern of the address
// Notes: Memory strobes are matched in order against a queue
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module snpce_engine_test
  import snpce_pkg::*;
;
  logic clk, rst_n, sclk, host_d, host_oe, dev_d, dev_oe, lock_n, busy;
  logic mem_wr, mem_row, mem_rd, er_f, er_e, er_u, er_c;
  logic last_d = 1'b0;
  logic [PTR_W-1:0] addr, waddr, ptr;
  logic [DATA_W-1:0] wdata, got;
  logic [40:0] exp_q[$];
  logic [15:0] seed = 16'h66dc;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // Released line shows the inverse of its last level, not a kind default
  wire sdat = dev_oe ? dev_d : (host_oe ? host_d : ~last_d);
  wire [DATA_W-1:0] rdata = addr[15:0] ^ 16'h3c5a;

  snpce_engine #(.ROW_WORDS(4), .SELF_CYC(8), .ROW_CYC(8), .BULK_CYC(8)) u_snpce_engine (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_SERIAL_CLOCK_LINE(sclk), .I_SERIAL_DATA_LINE(sdat),
    .O_SERIAL_DATA_LINE(dev_d), .O_SERIAL_DATA_LINE_OE(dev_oe), .I_CODE_LOCK_BIT_N(lock_n),
    .O_MEM_READ(mem_rd), .O_MEM_ADDR(addr), .I_MEM_RDATA(rdata), .O_MEM_WRITE(mem_wr),
    .O_MEM_WADDR(waddr), .O_MEM_WDATA(wdata), .O_MEM_ROW_ERASE(mem_row),
    .O_ERASE_FLASH(er_f), .O_ERASE_EE(er_e), .O_ERASE_UID(er_u), .O_ERASE_CFG(er_c),
    .O_BUSY(busy), .O_LOCATION_POINTER(ptr));
  snpce_host u_snpce_host (.o_sclk(sclk), .o_sdat(host_d), .o_sdat_oe(host_oe), .i_sdat(sdat));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dev_oe || host_oe) last_d <= sdat;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
    if (mem_wr) take({3'h1, waddr, wdata});
    if (mem_row) take({3'h2, addr, 16'h0000});
    if (mem_rd) take({3'h4, addr, 16'h0000});
    if (er_f | er_e | er_u | er_c) take({3'h3, 22'h000000, 12'h000, er_f, er_e, er_u, er_c});
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic take(input logic [40:0] seen);
    logic [40:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
    `CHK("mem event", e, seen)
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [7:0] c);
    u_snpce_host.put({16'h0000, c}, 8);
    gap(8);
  endtask
  task automatic idle();
    gap(8);
    for (int i = 0; i < 500 && busy !== 1'b0; i++) gap(1);
    gap(8);
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic load(input logic [7:0] c, input logic [15:0] d);
    cmd(c);
    u_snpce_host.put({7'h00, d, 1'b0}, 24);
    gap(8);
  endtask
  task automatic setp(input logic [PTR_W-1:0] p);
    cmd(CMD_PTR_LOAD);
    u_snpce_host.put({1'b0, p, 1'b0}, 24);
    gap(8);
  endtask
  task automatic rd(input logic [7:0] c, input logic [PTR_W-1:0] a, input logic [15:0] e);
    exp_q.push_back({3'h4, a, 16'h0000});
    cmd(c);
    u_snpce_host.get(got);
    gap(8);
    `CHK("readback", e, got)
  endtask
  task automatic wr(input logic [PTR_W-1:0] a, input logic [15:0] d);
    exp_q.push_back({3'h1, a, d});
  endtask
  task automatic bulk(input logic [PTR_W-1:0] p, input logic [3:0] f);
    setp(p);
    exp_q.push_back({3'h3, 22'h000000, 12'h000, f});
    cmd(CMD_BULK);
    idle();
  endtask

  initial begin
    logic [15:0] v[5];
    rst_n = 1'b0;
    lock_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    gap(3);
    setp(22'h000004);
    `CHK("pointer", 22'h000004, ptr)
    seed = lfsr(seed);
    v[0] = seed;
    load(CMD_LOAD_INC, v[0]);
    `CHK("pointer", 22'h000006, ptr)
    seed = lfsr(seed);
    v[1] = seed;
    load(CMD_LOAD, v[1]);
    `CHK("pointer", 22'h000006, ptr)
    cmd(CMD_INC);
    `CHK("pointer", 22'h000008, ptr)
    for (int i = 0; i < 4; i++) wr(22'(8 + 2 * i), (i < 2) ? 16'hffff : v[i - 2]);
    cmd(CMD_PROG_INT);
    idle();
    for (int i = 0; i < 4; i++) wr(22'(8 + 2 * i), 16'hffff);
    cmd(CMD_PROG_INT);
    idle();
    cmd(CMD_PROG_END);
    idle();
    setp(22'h000000);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      v[i] = seed;
      load(CMD_LOAD_INC, v[i]);
    end
    for (int i = 0; i < 4; i++) wr(22'(8 + 2 * i), v[(i == 0) ? 4 : i]);
    cmd(CMD_PROG_EXT);
    cmd(CMD_PROG_END);
    idle();
    setp(22'h000010);
    rd(CMD_READ_INC, 22'h000010, 16'h0010 ^ 16'h3c5a);
    `CHK("pointer", 22'h000012, ptr)
    setp(CFG_FIRST + 22'h000002);
    seed = lfsr(seed);
    load(CMD_LOAD, seed);
    wr(CFG_FIRST + 22'h000002, seed);
    cmd(CMD_PROG_INT);
    idle();
    load(CMD_LOAD, seed);
    cmd(CMD_PROG_EXT);
    cmd(CMD_PROG_END);
    idle();
    setp(EE_FIRST);
    cmd(CMD_INC);
    `CHK("pointer", EE_FIRST + EE_STEP, ptr)
    bulk(EE_FIRST, 4'b0100);
    bulk(CFG_FIRST, 4'b1011);
    setp(22'h000012);
    exp_q.push_back({3'h2, 22'h000012, 16'h0000});
    cmd(CMD_ROW);
    idle();
    lock_n = 1'b0;
    setp(22'h000020);
    rd(CMD_READ, 22'h000020, 16'h0000);
    `CHK("pointer", 22'h000020, ptr)
    setp(CFG_FIRST);
    rd(CMD_READ, CFG_FIRST, 16'h3c5a);
    setp(22'h000020);
    load(CMD_LOAD, seed);
    cmd(CMD_PROG_INT);
    idle();
    cmd(CMD_ROW);
    idle();
    bulk(22'h000000, 4'b1101);
    `CHK("events left", 32'd0, exp_q.size())
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("Compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
endmodule // snpce_engine_test
